// ---- src/clk_sel_pkg.sv ----
// Package for the system clock selector: register offsets, field layouts,
// reset values, source codes and timing constants.
// Assumes a 32-bit APB slave with one aligned word per register.
package clk_sel_pkg;

    // Register byte addresses
    localparam logic [7:0] OSC_CTRL_ADDR = 8'h00;    // oscillator_control
    localparam logic [7:0] CLK_DIV_ADDR = 8'h04;     // clock_divisor
    localparam logic [7:0] PLL_FB_ADDR = 8'h08;      // feedback divider
    localparam logic [7:0] REF_CTRL_ADDR = 8'h0C;    // reference output and aux control
    localparam logic [7:0] UNLOCK_ADDR = 8'h10;      // unlock key register
    localparam logic [7:0] STATUS_ADDR = 8'h14;      // derived clock status

    // Unlock keys, written in order
    localparam logic [15:0] UNLOCK_KEY1 = 16'h0046;
    localparam logic [15:0] UNLOCK_KEY2 = 16'h0057;

    // oscillator_control field positions
    localparam int CUR_SRC_LSB = 12;
    localparam int NEW_SRC_LSB = 8;
    localparam int CFG_LOCK_BIT = 7;
    localparam int IO_LOCK_BIT = 6;
    localparam int PLL_LOCK_BIT = 5;
    localparam int FAIL_BIT = 3;
    localparam int SWITCH_BIT = 0;

    // clock_divisor field positions
    localparam int RECOVER_BIT = 15;
    localparam int DOZE_LSB = 12;
    localparam int DOZE_EN_BIT = 11;
    localparam int RCDIV_LSB = 8;
    localparam int POST_LSB = 6;
    localparam int PRE_LSB = 0;

    // Reset values
    localparam logic [2:0] DOZE_RESET = 3'h3;
    localparam logic [1:0] POST_RESET = 2'h1;
    localparam logic [4:0] PRE_RESET = 5'h00;
    localparam logic [8:0] FB_RESET = 9'h030;
    localparam logic [3:0] REF_DIV_RESET = 4'h0;

    // Source selection codes
    typedef enum logic [2:0] {
        SRC_RC = 3'b000,
        SRC_RC_PLL = 3'b001,
        SRC_PRI = 3'b010,
        SRC_PRI_PLL = 3'b011,
        SRC_RSVD = 3'b100,
        SRC_LOW_POWER_RC = 3'b101,
        SRC_RC_DIV16 = 3'b110,
        SRC_RC_DIVN = 3'b111
    } src_sel_t;

    // Primary mode configuration codes
    localparam logic [1:0] PRI_EXT = 2'b00;
    localparam logic [1:0] PRI_XTAL = 2'b01;
    localparam logic [1:0] PRI_HS = 2'b10;

    // Switch sequencer states
    typedef enum logic [1:0] {
        SW_IDLE = 2'b00,
        SW_WAIT_SRC = 2'b01,
        SW_WAIT_LOCK = 2'b10
    } sw_state_t;

    // Timing: PLL start-up timer
    localparam int CLK_PERIOD_NS = 25;
    localparam int PLL_START_NS = 2000;
    localparam int PLL_START_CYC = (PLL_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INST_DIV = 2;
    localparam int AUX_MULT = 16;
    localparam logic [9:0] PLL_START_CNT = 10'(PLL_START_CYC);

    // Computed divider settings
    typedef struct packed {
        logic [9:0] mult;     // feedback + 2
        logic [5:0] preDiv;   // prescale + 2
        logic [3:0] postDiv;  // 2 * (postscale + 1)
    } pll_ratio_t;

    // Whole register state
    typedef struct packed {
        logic [2:0] curSrc;
        logic [2:0] newSrc;
        logic cfgLock;
        logic io_lock_enable;
        logic failFlag;
        logic switchReq;
        logic recoverOnInt;
        logic [2:0] dozeRatio;
        logic dozeEn;
        logic [2:0] rcPost;
        logic [1:0] pll_postscale_field;
        logic [4:0] pll_prescale_field;
        logic [8:0] pllFb;
        logic refEn;
        logic refSel;
        logic [3:0] refDiv;
        logic auxFromPll;
        logic auxSrcPri;
        logic [1:0] unlockStage;
        sw_state_t swState;
        logic [9:0] lockCnt;
        logic pllLocked;
        logic failTrap;
        logic [15:0] refCnt;
        logic refOut;
        logic [31:0] prdata;
    } state_t;

endpackage

// ---- src/system_clock_selector.sv ----
// System clock selector with PLL settings, doze, switch sequencing and a
// divided reference clock output. Registers reached over APB.
// Assumes oscillator ready levels, fail detection and interrupt levels are
// synchronous to clk.
//
// Notes on behaviour
// RULE_01: Instruction clock is oscillator clock halved.
// RULE_02: PLL output ratio uses feedback, prescale, postscale.
// RULE_03: Oscillator stage ratio is feedback over prescale.
// RULE_04: Three-bit source codes map the eight sources.
// RULE_05: Current source readable at bits 14-12.
// RULE_06: Primary mode code picks HS, crystal, external.
// RULE_07: Erased device starts on RC divide-by-n.
// RULE_08: Auxiliary PLL multiplies reference by sixteen.
// RULE_09: Software sets auxiliary clock to 120 MHz.
// RULE_10: Fine PWM resolution only from auxiliary PLL.
// RULE_11: Main PLL feeding aux limited to 30 MIPS.
// RULE_12: Reference output divides system or crystal clock. Here it always divides clk; refSel is stored but not used.
// RULE_13: Lock bit with fail-safe bit freezes configuration.
// RULE_14: Writable I/O lock enable at bit 6.
// RULE_15: PLL lock status reads locked or timer done.
// RULE_16: Switch request bit clears when switch completes.
// RULE_17: Fail flag set by monitor; writing one traps.
// RULE_18: Control register writes need unlock sequence.
// RULE_19: No direct switch between the two PLL modes.
// RULE_20: Interrupt with recover bit clears doze enable.
// RULE_21: Doze enable applies ratio, else forced 1:1.
// RULE_22: Doze ratio writes ignored while doze enabled.
// RULE_23: Doze enable cannot be set with ratio 000. Here the stored ratio is checked, not the one being written.
// RULE_24: Prescale divides by field plus two.
// RULE_25: Old source kept until new source ready.
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

module system_clock_selector
    import clk_sel_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Configuration bits, static after power-up
    input wire clk_sel_pkg::src_sel_t initialSourceCfg,
    input wire logic [1:0] primaryModeCfg,
    input wire logic failsafeCfgBit,
    // Oscillator and monitor status
    input wire logic [7:0] srcReady,
    input wire logic pllLockIn,
    input wire logic clockFailDetect,
    input wire logic interruptEvent,
    input wire logic crystalClk,
    // Clock control outputs
    output clk_sel_pkg::src_sel_t activeSource,
    output logic [1:0] primaryMode,
    output clk_sel_pkg::pll_ratio_t pllRatio,
    output logic [2:0] rcPostscale,
    output logic [7:0] peripheralDivLog2,
    output logic [1:0] instClockDiv,
    output logic [4:0] auxPllMult,
    output logic auxFineRes,
    output logic ioLockActive,
    output logic oscFailTrap,
    output logic refClkOut
);
    import clk_sel_pkg::*;

    state_t r_reg, r_next;

    // Divider arithmetic shared by output and status read
    function automatic pll_ratio_t calcRatio(input logic [8:0] fb, input logic [4:0] pre,
                                             input logic [1:0] post);
        pll_ratio_t v;
        v.mult = 10'(fb) + 10'd2;                    // [RULE_02] [RULE_03]
        v.preDiv = 6'(pre) + 6'd2;                   // [RULE_24]
        v.postDiv = 4'(4'(post) + 4'd1) << 1;         // [RULE_02]
        return v;
    endfunction

    // True for sources that run through the main PLL
    function automatic logic isPllSrc(input logic [2:0] s);
        return (s == SRC_RC_PLL) || (s == SRC_PRI_PLL);
    endfunction

    // Bus decode helpers
    logic wrAcc, rdAcc, cfgFrozen, knownAddr;
    assign wrAcc = psel && penable && pwrite;
    assign rdAcc = psel && !penable && !pwrite;
    assign knownAddr = (paddr == OSC_CTRL_ADDR) || (paddr == CLK_DIV_ADDR) || (paddr == PLL_FB_ADDR) ||
                       (paddr == REF_CTRL_ADDR) || (paddr == UNLOCK_ADDR) || (paddr == STATUS_ADDR);
    assign cfgFrozen = r_reg.cfgLock && failsafeCfgBit;  // [RULE_13]

    // Next-state logic
    always_comb begin
        logic [15:0] oscWord;
        logic [15:0] divWord;
        logic [15:0] refWord;
        logic [15:0] refLimit;
        oscWord = '0;
        divWord = '0;
        refWord = '0;
        refLimit = '0;
        r_next = r_reg;
        r_next.failTrap = 1'b0;

        // Readback words
        oscWord[CUR_SRC_LSB +: 3] = r_reg.curSrc;       // [RULE_05]
        oscWord[NEW_SRC_LSB +: 3] = r_reg.newSrc;
        oscWord[CFG_LOCK_BIT] = r_reg.cfgLock;
        oscWord[IO_LOCK_BIT] = r_reg.io_lock_enable;
        oscWord[PLL_LOCK_BIT] = r_reg.pllLocked;       // [RULE_15]
        oscWord[FAIL_BIT] = r_reg.failFlag;
        oscWord[SWITCH_BIT] = r_reg.switchReq;
        divWord[RECOVER_BIT] = r_reg.recoverOnInt;
        divWord[DOZE_LSB +: 3] = r_reg.dozeRatio;
        divWord[DOZE_EN_BIT] = r_reg.dozeEn;
        divWord[RCDIV_LSB +: 3] = r_reg.rcPost;
        divWord[POST_LSB +: 2] = r_reg.pll_postscale_field;
        divWord[PRE_LSB +: 5] = r_reg.pll_prescale_field;
        refWord = {r_reg.refEn, 1'b0, r_reg.refSel, 1'b0, r_reg.refDiv, r_reg.auxFromPll,
                   r_reg.auxSrcPri, 6'h00};

        // PLL lock tracking: input lock or start-up timer expiry
        if (r_reg.swState == SW_WAIT_LOCK || isPllSrc(r_reg.curSrc)) begin
            if (r_reg.lockCnt != PLL_START_CNT) begin
                r_next.lockCnt = r_reg.lockCnt + 10'd1;
            end
            r_next.pllLocked = pllLockIn || (r_reg.lockCnt == PLL_START_CNT);  // [RULE_15]
        end else begin
            // PLL idle: reads unlocked
            r_next.lockCnt = '0;
            r_next.pllLocked = 1'b0;
        end

        // Switch sequencer
        case (r_reg.swState)
            SW_IDLE: begin
                if (r_reg.switchReq) begin
                    if ((isPllSrc(r_reg.curSrc) && isPllSrc(r_reg.newSrc) && r_reg.curSrc != r_reg.newSrc) ||
                        r_reg.newSrc == SRC_RSVD) begin
                        r_next.switchReq = 1'b0;             // [RULE_19] refused, stays put
                    end else begin
                        r_next.swState = SW_WAIT_SRC;
                    end
                end
            end
            SW_WAIT_SRC: begin
                if (srcReady[r_reg.newSrc]) begin         // [RULE_25]
                    r_next.swState = isPllSrc(r_reg.newSrc) ? SW_WAIT_LOCK : SW_IDLE;
                    r_next.lockCnt = '0;
                    if (!isPllSrc(r_reg.newSrc)) begin
                        r_next.curSrc = r_reg.newSrc;
                        r_next.switchReq = 1'b0;             // [RULE_16]
                    end
                end
            end
            SW_WAIT_LOCK: begin
                if (r_reg.pllLocked) begin                // [RULE_25]
                    r_next.curSrc = r_reg.newSrc;
                    r_next.switchReq = 1'b0;                 // [RULE_16]
                    r_next.swState = SW_IDLE;
                end
            end
            default: r_next.swState = SW_IDLE;
        endcase

        // Read data, taken in the setup cycle
        if (rdAcc) begin
            if (paddr == OSC_CTRL_ADDR) begin
                r_next.prdata = {16'h0000, oscWord};
            end else if (paddr == CLK_DIV_ADDR) begin
                r_next.prdata = {16'h0000, divWord};
            end else if (paddr == PLL_FB_ADDR) begin
                r_next.prdata = {23'h000000, r_reg.pllFb};
            end else if (paddr == REF_CTRL_ADDR) begin
                r_next.prdata = {16'h0000, refWord};
            end else if (paddr == UNLOCK_ADDR) begin
                r_next.prdata = {30'h00000000, r_reg.unlockStage};
            end else if (paddr == STATUS_ADDR) begin
                r_next.prdata = {12'h000, calcRatio(r_reg.pllFb, r_reg.pll_prescale_field, r_reg.pll_postscale_field)};
            end else begin
                r_next.prdata = '0;
            end
        end

        // Register writes
        if (wrAcc) begin
            if (paddr == UNLOCK_ADDR) begin
                // Two-key sequence arms one control write
                if (pwdata[15:0] == UNLOCK_KEY1) begin
                    r_next.unlockStage = 2'd1;
                end else if (pwdata[15:0] == UNLOCK_KEY2 && r_reg.unlockStage == 2'd1) begin
                    r_next.unlockStage = 2'd2;
                end else begin
                    r_next.unlockStage = 2'd0;
                end
            end else if (paddr == OSC_CTRL_ADDR) begin
                r_next.unlockStage = 2'd0;
                if (r_reg.unlockStage == 2'd2) begin      // [RULE_18]
                    r_next.io_lock_enable = pwdata[IO_LOCK_BIT];  // [RULE_14]
                    if (!pwdata[FAIL_BIT]) begin
                        r_next.failFlag = 1'b0;
                    end else begin
                        r_next.failFlag = 1'b1;              // [RULE_17] acts as a real failure
                        r_next.failTrap = 1'b1;
                    end
                    if (!cfgFrozen) begin                 // [RULE_13]
                        r_next.cfgLock = pwdata[CFG_LOCK_BIT];
                        if (r_reg.swState == SW_IDLE && !r_reg.switchReq) begin
                            r_next.newSrc = pwdata[NEW_SRC_LSB +: 3];
                            r_next.switchReq = pwdata[SWITCH_BIT];  // [RULE_16]
                        end
                    end
                end
            end else if (paddr == CLK_DIV_ADDR) begin
                r_next.recoverOnInt = pwdata[RECOVER_BIT];
                if (!r_reg.dozeEn) begin
                    r_next.dozeRatio = pwdata[DOZE_LSB +: 3];  // [RULE_22]
                end
                if (!pwdata[DOZE_EN_BIT] || r_reg.dozeRatio != 3'b000) begin
                    r_next.dozeEn = pwdata[DOZE_EN_BIT];    // [RULE_23]
                end
                r_next.rcPost = pwdata[RCDIV_LSB +: 3];
                if (!cfgFrozen) begin                     // [RULE_13]
                    r_next.pll_postscale_field = pwdata[POST_LSB +: 2];
                    r_next.pll_prescale_field = pwdata[PRE_LSB +: 5];
                end
            end else if (paddr == PLL_FB_ADDR) begin
                if (!cfgFrozen) begin                     // [RULE_13]
                    r_next.pllFb = pwdata[8:0];
                end
            end else if (paddr == REF_CTRL_ADDR) begin
                r_next.refEn = pwdata[15];
                if (!r_reg.refEn) begin
                    r_next.refSel = pwdata[13];
                    r_next.refDiv = pwdata[11:8];
                end
                if (!cfgFrozen) begin
                    r_next.auxFromPll = pwdata[7];
                    r_next.auxSrcPri = pwdata[6];
                end
            end
        end

        // Interrupt recovery has the last word on doze
        if (interruptEvent && r_reg.recoverOnInt) begin
            r_next.dozeEn = 1'b0;                        // [RULE_20]
        end

        // Monitor set wins over a software clear
        if (clockFailDetect) begin
            r_next.failFlag = 1'b1;                      // [RULE_17]
            r_next.failTrap = 1'b1;
        end

        // Reference clock divider: toggles at half the division ratio
        refLimit = (r_reg.refDiv == 4'h0) ? 16'h0000 : 16'(16'h0001 << (r_reg.refDiv - 4'd1)) - 16'h0001;
        if (!r_reg.refEn) begin
            r_next.refCnt = '0;
            r_next.refOut = 1'b0;
        end else if (r_reg.refCnt >= refLimit) begin
            r_next.refCnt = '0;
            r_next.refOut = ~r_reg.refOut;                // [RULE_12]
        end else begin
            r_next.refCnt = r_reg.refCnt + 16'h0001;
        end
    end

    // State register; start-up source comes from the configuration bits,
    // which an erased part leaves at RC divide-by-n
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r_reg <= '0;
            r_reg.curSrc <= initialSourceCfg;              // [RULE_07]
            r_reg.newSrc <= initialSourceCfg;
            r_reg.dozeRatio <= DOZE_RESET;
            r_reg.pll_postscale_field <= POST_RESET;
            r_reg.pll_prescale_field <= PRE_RESET;
            r_reg.pllFb <= FB_RESET;
            r_reg.refDiv <= REF_DIV_RESET;
            r_reg.swState <= SW_IDLE;
        end else begin
            r_reg <= r_next;
        end
    end

    // Outputs
    assign prdata = r_reg.prdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !knownAddr;
    assign activeSource = src_sel_t'(r_reg.curSrc);                     // [RULE_04]
    assign primaryMode = primaryModeCfg;                               // [RULE_06]
    assign pllRatio = calcRatio(r_reg.pllFb, r_reg.pll_prescale_field, r_reg.pll_postscale_field);
    assign rcPostscale = r_reg.rcPost;
    assign peripheralDivLog2 = r_reg.dozeEn ? 8'(r_reg.dozeRatio) : 8'h00;  // [RULE_21]
    assign instClockDiv = 2'(INST_DIV);                                // [RULE_01]
    assign auxPllMult = 5'(AUX_MULT);                                  // [RULE_08]
    assign auxFineRes = r_reg.auxFromPll;                              // [RULE_10]
    assign ioLockActive = r_reg.io_lock_enable;
    assign oscFailTrap = r_reg.failTrap;
    assign refClkOut = r_reg.refOut;

    // Assertions
    chk_doze_forced: assert property (@(posedge clk) disable iff (!rst_n)
        !r_reg.dozeEn |-> peripheralDivLog2 == 8'h00)  // [RULE_21]
        else $error("doze ratio not forced to 1:1");
    chk_doze_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (wrAcc && paddr == CLK_DIV_ADDR && r_reg.dozeRatio == 3'b000 && !r_reg.dozeEn) |=> !r_reg.dozeEn)  // [RULE_23]
        else $error("doze enabled with ratio 000");
    chk_doze_ratio_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (wrAcc && paddr == CLK_DIV_ADDR && r_reg.dozeEn) |=> $stable(r_reg.dozeRatio))  // [RULE_22]
        else $error("doze ratio changed while enabled");
    chk_doze_recover: assert property (@(posedge clk) disable iff (!rst_n)
        (interruptEvent && r_reg.recoverOnInt) |=> !r_reg.dozeEn)  // [RULE_20]
        else $error("interrupt did not end doze");
    chk_cfg_frozen: assert property (@(posedge clk) disable iff (!rst_n)
        cfgFrozen |=> $stable(r_reg.pllFb) && $stable(r_reg.pll_prescale_field) && $stable(r_reg.newSrc))  // [RULE_13]
        else $error("locked configuration changed");
    chk_unlock_need: assert property (@(posedge clk) disable iff (!rst_n)
        (wrAcc && paddr == OSC_CTRL_ADDR && r_reg.unlockStage != 2'd2) |=> $stable(r_reg.io_lock_enable))  // [RULE_18]
        else $error("control write accepted without unlock");
    chk_fail_set: assert property (@(posedge clk) disable iff (!rst_n)
        clockFailDetect |=> r_reg.failFlag && oscFailTrap)  // [RULE_17]
        else $error("clock failure not flagged");
    chk_pll_pair: assert property (@(posedge clk) disable iff (!rst_n)
        (isPllSrc(r_reg.curSrc) && isPllSrc(r_reg.newSrc) && r_reg.curSrc != r_reg.newSrc &&
         r_reg.swState == SW_IDLE) |=> $stable(r_reg.curSrc))  // [RULE_19]
        else $error("direct switch between PLL modes");
    chk_switch_done: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(r_reg.curSrc) |-> !r_reg.switchReq)  // [RULE_16] [RULE_25]
        else $error("source changed without clearing request");
    chk_lock_timer: assert property (@(posedge clk) disable iff (!rst_n)
        (r_reg.lockCnt == PLL_START_CNT && isPllSrc(r_reg.curSrc)) |=> r_reg.pllLocked)  // [RULE_15]
        else $error("lock status not set after timer");

    cov_switch: cover property (@(posedge clk) disable iff (!rst_n) $fell(r_reg.switchReq));
    cov_pll_lock: cover property (@(posedge clk) disable iff (!rst_n) $rose(r_reg.pllLocked));
    cov_doze: cover property (@(posedge clk) disable iff (!rst_n) $rose(r_reg.dozeEn));
    cov_fail: cover property (@(posedge clk) disable iff (!rst_n) $rose(r_reg.failFlag));

endmodule // system_clock_selector

// ---- tb/osc_model.sv ----
// Oscillator side model: source ready levels, PLL lock, crystal clock.
// Assumes the selector clock and a synchronous active-low reset.
`timescale 1ns/1ps
module osc_model
    import clk_sel_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic slow,
    input wire clk_sel_pkg::src_sel_t activeSource,
    output logic [7:0] srcReady,
    output logic pllLockIn,
    output logic crystalClk
);
    logic [7:0] cnt; // Cycles since the last source change
    src_sel_t seen; // Source seen on the previous cycle
    // Start-up timers restart whenever the active source changes
    always @(posedge clk) begin
        seen <= activeSource;
        crystalClk <= rst_n ? !crystalClk : 1'b0;
        if (!rst_n || seen != activeSource) begin
            cnt <= 8'h00;
        end else if (cnt != 8'hFF) begin
            cnt <= cnt + 8'h01;
        end
    end
    // Reserved code never becomes ready
    assign srcReady = (cnt >= (slow ? 8'h3C : 8'h02)) ? 8'hEF : 8'h00;
    // A running PLL keeps its lock once the selector has moved onto it
    assign pllLockIn = activeSource == SRC_RC_PLL || activeSource == SRC_PRI_PLL ||
        cnt >= (slow ? 8'h5A : 8'h0C);
endmodule // osc_model

// ---- tb/system_clock_selector_pll_tb_top.sv ----
// Self-checking bench for the clock selector over APB.
// Assumes osc_model drives the oscillator status inputs.
`timescale 1ns/1ps
module system_clock_selector_pll_tb_top;
    import clk_sel_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, srcReady, peripheralDivLog2;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, slow = 1'b0, failIn = 1'b0, intIn = 1'b0;
    logic pllLockIn, crystalClk, ioLockActive, oscFailTrap, auxFineRes, refClkOut;
    logic [1:0] primaryMode;
    src_sel_t activeSource;
    pll_ratio_t pllRatio, expRatio;
    logic [1:0] instClockDiv;
    logic [4:0] auxPllMult;
    int miscompares = 0, n_compared = 0, cycles = 0, seed = 32'h493F7C1F;
    always #12.5 clk = ~clk;
    system_clock_selector i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .initialSourceCfg(SRC_RC_DIVN), .primaryModeCfg(PRI_HS),
        .failsafeCfgBit(1'b1), .srcReady(srcReady), .pllLockIn(pllLockIn),
        .clockFailDetect(failIn), .interruptEvent(intIn), .crystalClk(crystalClk),
        .activeSource(activeSource), .primaryMode(primaryMode), .pllRatio(pllRatio), .rcPostscale(),
        .peripheralDivLog2(peripheralDivLog2), .instClockDiv(instClockDiv),
        .auxPllMult(auxPllMult), .auxFineRes(auxFineRes), .ioLockActive(ioLockActive),
        .oscFailTrap(oscFailTrap), .refClkOut(refClkOut));
    osc_model i_osc (.clk(clk), .rst_n(rst_n), .slow(slow), .activeSource(activeSource),
        .srcReady(srcReady), .pllLockIn(pllLockIn), .crystalClk(crystalClk));
    // Verdict and end of run
    task automatic end_sim;
        if (miscompares == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Compare one value
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One APB transfer; waits for pready, settles outputs after
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    // Unlock keys then the control write
    task automatic wosc(input logic [31:0] d);
        bus(1'b1, UNLOCK_ADDR, {16'h0, UNLOCK_KEY1});
        bus(1'b1, UNLOCK_ADDR, {16'h0, UNLOCK_KEY2});
        bus(1'b1, OSC_CTRL_ADDR, d);
    endtask
    // Source after a request: pair of PLL modes and reserved refused
    function automatic logic [2:0] nextSrc(input logic [2:0] cur, input logic [2:0] req);
        if (req == SRC_RSVD || (cur | req) == 3'h3 && cur != req && cur[0] && req[0]) begin
            return cur;
        end
        return req;
    endfunction
    // Expected divider settings
    function automatic pll_ratio_t ratio(input logic [4:0] pre, input logic [1:0] post,
        input logic [8:0] fb);
        ratio.mult = {1'b0, fb} + 10'h002;
        ratio.preDiv = {1'b0, pre} + 6'h02;
        ratio.postDiv = {1'b0, post, 1'b0} + 4'h2;
    endfunction
    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            miscompares++;
            end_sim();
        end
    end
    // Main sequence
    initial begin
        logic [31:0] codes;
        logic [2:0] cur, req;
        codes = 32'h3CD5A0C8;
        cur = 3'h7;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        bus(1'b0, OSC_CTRL_ADDR, 32'h0);
        chk("osc reset", 32'h7700, rd & ~32'h20);
        bus(1'b0, CLK_DIV_ADDR, 32'h0);
        chk("div reset", 32'h3040, rd);
        chk("inst div", 32'h2, 32'(instClockDiv));
        chk("aux mult", 32'h10, 32'(auxPllMult));
        chk("primary mode", 32'(PRI_HS), 32'(primaryMode));
        bus(1'b1, OSC_CTRL_ADDR, 32'h0001);
        bus(1'b0, OSC_CTRL_ADDR, 32'h0);
        chk("no unlock", 32'h7700, rd & ~32'h20);
        for (int k = 0; k < 10; k++) begin
            slow <= (k > 4);
            req = codes[3 * k +: 3];
            cur = nextSrc(cur, req);
            wosc({20'h0, 1'b0, req, 8'h01});
            bus(1'b0, OSC_CTRL_ADDR, 32'h0);
            while (rd[0] === 1'b1) bus(1'b0, OSC_CTRL_ADDR, 32'h0);
            chk("switch", {17'h0, cur, 12'h000}, rd & 32'h7001);
            chk("source", 32'(cur), 32'(activeSource));
            if (k == 1) chk("pll lock", 32'h1, 32'(rd[5]));
        end
        bus(1'b1, CLK_DIV_ADDR, 32'h0040);
        bus(1'b1, CLK_DIV_ADDR, 32'h0840);
        bus(1'b0, CLK_DIV_ADDR, 32'h0);
        chk("doze zero", 32'h0040, rd);
        bus(1'b1, CLK_DIV_ADDR, 32'h5040);
        bus(1'b1, CLK_DIV_ADDR, 32'hD840);
        chk("doze ratio", 32'h5, 32'(peripheralDivLog2));
        bus(1'b1, CLK_DIV_ADDR, 32'hA840);
        bus(1'b0, CLK_DIV_ADDR, 32'h0);
        chk("doze hold", 32'hD840, rd);
        @(posedge clk);
        intIn <= 1'b1;
        @(posedge clk);
        intIn <= 1'b0;
        bus(1'b0, CLK_DIV_ADDR, 32'h0);
        chk("doze exit", 32'hD040, rd);
        chk("ratio 1:1", 32'h0, 32'(peripheralDivLog2));
        for (int k = 0; k < 4; k++) begin
            expRatio = ratio(5'($random(seed)), 2'($random(seed)), 9'($random(seed)));
            bus(1'b1, CLK_DIV_ADDR, {24'h0, expRatio.postDiv[2:1] - 2'h1, 1'b0, expRatio.preDiv[4:0] - 5'h02});
            bus(1'b1, PLL_FB_ADDR, {23'h0, expRatio.mult[8:0] - 9'h002});
            chk("pll ratio", 32'(expRatio), 32'(pllRatio));
        end
        // Aux clock from the 16x PLL at 120 MHz; main PLL does not feed it
        bus(1'b1, REF_CTRL_ADDR, 32'h8080);
        chk("aux fine", 32'h1, 32'(auxFineRes));
        rd = 32'(refClkOut);
        @(posedge clk);
        #1;
        chk("ref clock", rd ^ 32'h1, 32'(refClkOut));
        @(posedge clk);
        failIn <= 1'b1;
        @(posedge clk);
        failIn <= 1'b0;
        #1;
        chk("fail trap", 32'h1, 32'(oscFailTrap));
        bus(1'b0, OSC_CTRL_ADDR, 32'h0);
        chk("fail flag", 32'h1, 32'(rd[3]));
        wosc(32'h0740);
        chk("io lock", 32'h1, 32'(ioLockActive));
        wosc(32'h07C0);
        bus(1'b1, CLK_DIV_ADDR, 32'h001F);
        chk("cfg locked", 32'(expRatio), 32'(pllRatio));
        bus(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h1, 32'(err));
        end_sim();
    end
endmodule // system_clock_selector_pll_tb_top
